// File: rtl/charge_voltage_limit_pkg.sv
// Package: register map, field layouts and strap-selected defaults of the setpoint registers
package charge_voltage_limit_pkg;

    // =========================================================
    // Register offsets (SMBus command codes)
    localparam logic [7:0] CHARGE_VOLTAGE_LIMIT_OFS = 8'h15;
    localparam logic [7:0] SYSTEM_VOLTAGE_FLOOR_OFS = 8'h3e;
    localparam logic [7:0] CHARGE_CURRENT_SETPOINT_OFS = 8'h14;

    // =========================================================
    // Field layouts
    localparam int CVL_LSB = 4;
    localparam int CVL_MSB = 14;
    localparam int SVF_LSB = 8;
    localparam int SVF_MSB = 13;
    localparam logic [15:0] CVL_RSVD_MASK = 16'h8000;
    localparam logic [15:0] SVF_RSVD_MASK = 16'hc000;
    localparam logic [15:0] CVL_FIELD_MASK = 16'h7ff0;
    localparam logic [15:0] SVF_FIELD_MASK = 16'h3f00;

    // =========================================================
    // Legal ranges as field codes: 1024 mV to 19200 mV at 16 mV, 1024 mV to 16128 mV at 256 mV
    localparam int CVL_STEP_MV = 16;
    localparam int SVF_STEP_MV = 256;
    localparam logic [10:0] CVL_CODE_MIN = 11'(1024 / CVL_STEP_MV);
    localparam logic [10:0] CVL_CODE_MAX = 11'(19200 / CVL_STEP_MV);
    localparam logic [5:0] SVF_CODE_MIN = 6'(1024 / SVF_STEP_MV);
    localparam logic [5:0] SVF_CODE_MAX = 6'(16128 / SVF_STEP_MV);

    // =========================================================
    // Reset values per cell count (index 0 = one cell)
    localparam logic [15:0] CVL_DEFAULT_1S = 16'h1060;
    localparam logic [15:0] CVL_DEFAULT_2S = 16'h20d0;
    localparam logic [15:0] CVL_DEFAULT_3S = 16'h3130;
    localparam logic [15:0] CVL_DEFAULT_4S = 16'h41a0;
    localparam logic [15:0] SVF_DEFAULT_1S = 16'h0e00;
    localparam logic [15:0] SVF_DEFAULT_2S = 16'h1800;
    localparam logic [15:0] SVF_DEFAULT_3S = 16'h2400;
    localparam logic [15:0] SVF_DEFAULT_4S = 16'h3000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    // Edges after reset release before the synchronised strap is trusted
    localparam logic [1:0] STRAP_SETTLE_COUNT = 2'h2;

    typedef enum logic [1:0] {
        CELLS_1 = 2'b00,
        CELLS_2 = 2'b01,
        CELLS_3 = 2'b10,
        CELLS_4 = 2'b11
    } cell_count_t;

    // Host word command as the SMBus slave front end delivers it
    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [7:0] cmd;
        logic [15:0] data;
    } word_cmd_t;

endpackage : charge_voltage_limit_pkg

// File: rtl/strap_sync.sv
// Two-flop synchroniser for the cell-count strap pin
`timescale 1ns/100ps
module strap_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] pinIn,
    output logic [1:0] pinSync
);
    logic [1:0] stage1Reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1Reg <= 2'b00;
            pinSync <= 2'b00;
        end else begin
            stage1Reg <= pinIn;
            pinSync <= stage1Reg;
        end
    end
endmodule : strap_sync

// File: rtl/charge_voltage_limit_regs.sv
// Charge voltage limit and system voltage floor setpoint registers
`timescale 1ns/100ps
module charge_voltage_limit_regs
    import charge_voltage_limit_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] cell_count_strap_pin,
    input charge_voltage_limit_pkg::word_cmd_t hostCmd,
    output logic [15:0] rdData,
    output logic rdValid,
    output logic wrInvalid,
    output logic [15:0] chargeVoltageLimit,
    output logic [15:0] systemVoltageFloor,
    output logic chargeCurrentClear
);
    import charge_voltage_limit_pkg::*;

    // =========================================================
    // Strap capture
    logic [1:0] strapSync;
    logic strapTakenReg;
    logic [1:0] cellsReg;

    strap_sync strapSyncInst (
        .sys_clk(sys_clk),
        .rst(rst),
        .pinIn(cell_count_strap_pin),
        .pinSync(strapSync)
    );

    // Strap is taken once after release, after the synchroniser has filled
    logic [1:0] settleReg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            settleReg <= 2'b00;
            strapTakenReg <= 1'b0;
            cellsReg <= 2'b00;
        end else if (!strapTakenReg) begin
            settleReg <= settleReg + 2'b01;
            if (settleReg == STRAP_SETTLE_COUNT) begin
                strapTakenReg <= 1'b1;
                cellsReg <= strapSync;
            end
        end
    end

    // =========================================================
    // Strap-selected defaults
    wire [15:0] cvlDefault;
    wire [15:0] svfDefault;
    assign cvlDefault = (cellsReg == CELLS_1) ? CVL_DEFAULT_1S :
                        (cellsReg == CELLS_2) ? CVL_DEFAULT_2S :
                        (cellsReg == CELLS_3) ? CVL_DEFAULT_3S : CVL_DEFAULT_4S;
    assign svfDefault = (cellsReg == CELLS_1) ? SVF_DEFAULT_1S :
                        (cellsReg == CELLS_2) ? SVF_DEFAULT_2S :
                        (cellsReg == CELLS_3) ? SVF_DEFAULT_3S : SVF_DEFAULT_4S;

    // =========================================================
    // Write decode and validation
    wire hitCvl;
    wire hitSvf;
    wire [10:0] cvlCode;
    wire [5:0] svfCode;
    wire cvlRsvdBad;
    wire svfRsvdBad;
    wire cvlZero;
    wire cvlInRange;
    wire svfInRange;
    wire cvlLoad;
    wire cvlReload;
    wire svfLoad;

    // floor is reached only by a word write to its command
    assign hitCvl = hostCmd.wrStb && (hostCmd.cmd == CHARGE_VOLTAGE_LIMIT_OFS);
    assign hitSvf = hostCmd.wrStb && (hostCmd.cmd == SYSTEM_VOLTAGE_FLOOR_OFS);
    // field bits 14:4, low nibble ignored
    assign cvlCode = hostCmd.data[CVL_MSB:CVL_LSB];
    // field bits 13:8, low byte ignored
    assign svfCode = hostCmd.data[SVF_MSB:SVF_LSB];
    // reserved upper bits must be zero
    assign cvlRsvdBad = |(hostCmd.data & CVL_RSVD_MASK);
    assign svfRsvdBad = |(hostCmd.data & SVF_RSVD_MASK);
    // Zero means the whole encoded field; ignored low bits do not count
    assign cvlZero = (cvlCode == 11'h000);
    assign cvlInRange = (cvlCode >= CVL_CODE_MIN) && (cvlCode <= CVL_CODE_MAX);
    assign svfInRange = (svfCode >= SVF_CODE_MIN) && (svfCode <= SVF_CODE_MAX);
    assign cvlLoad = hitCvl && !cvlRsvdBad && cvlInRange;
    assign cvlReload = hitCvl && !cvlRsvdBad && cvlZero;
    assign svfLoad = hitSvf && !svfRsvdBad && svfInRange;

    // =========================================================
    // Registers
    logic [15:0] cvlReg;
    logic [15:0] svfReg;
    logic loadedReg;
    wire [15:0] cvlNext;
    wire [15:0] svfNext;

    // Until loadedReg is set, one edge after the strap is caught, the registers track the default each cycle
    assign cvlNext = (!loadedReg || cvlReload) ? cvlDefault :
                     cvlLoad ? (hostCmd.data & CVL_FIELD_MASK) : cvlReg;
    assign svfNext = !loadedReg ? svfDefault :
                     svfLoad ? (hostCmd.data & SVF_FIELD_MASK) : svfReg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cvlReg <= ZERO_WORD;
            svfReg <= ZERO_WORD;
            loadedReg <= 1'b0;
        end else begin
            cvlReg <= cvlNext;
            svfReg <= svfNext;
            loadedReg <= strapTakenReg;
        end
    end

    assign chargeVoltageLimit = cvlReg;
    assign systemVoltageFloor = svfReg;

    // =========================================================
    // Side effects and read-back
    wire [15:0] rdMux;
    // held value, reserved bits already zero
    assign rdMux = (hostCmd.cmd == CHARGE_VOLTAGE_LIMIT_OFS) ? cvlReg :
                   (hostCmd.cmd == SYSTEM_VOLTAGE_FLOOR_OFS) ? svfReg : ZERO_WORD;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chargeCurrentClear <= 1'b0;
            wrInvalid <= 1'b0;
            rdData <= ZERO_WORD;
            rdValid <= 1'b0;
        end else begin
            chargeCurrentClear <= cvlReload;
            wrInvalid <= (hitCvl && !cvlLoad && !cvlReload) || (hitSvf && !svfLoad);
            rdValid <= hostCmd.rdStb;
            if (hostCmd.rdStb) begin
                rdData <= rdMux;
            end
        end
    end

    // =========================================================
    // Assertions
    // rejected floor write keeps contents
    svf_reject_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (loadedReg && hitSvf && !svfLoad) |=> (svfReg == $past(svfReg)))
        else $error("floor changed on rejected write");

    // floor always inside legal codes once loaded
    svf_range_a: assert property (@(posedge sys_clk) disable iff (rst)
        loadedReg |-> (svfReg[SVF_MSB:SVF_LSB] >= SVF_CODE_MIN && svfReg[SVF_MSB:SVF_LSB] <= SVF_CODE_MAX))
        else $error("floor outside legal range");

    cvl_reject_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (loadedReg && hitCvl && !cvlLoad && !cvlReload) |=> $stable(cvlReg))
        else $error("limit changed on rejected write");

    rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        ((cvlReg & CVL_RSVD_MASK) == ZERO_WORD) && ((svfReg & SVF_RSVD_MASK) == ZERO_WORD))
        else $error("reserved bit held");

    // low nibble of limit reads zero
    cvl_low_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        cvlReg[CVL_LSB-1:0] == 4'h0)
        else $error("limit low nibble nonzero");

    // low byte of floor reads zero
    svf_low_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        svfReg[SVF_LSB-1:0] == 8'h00)
        else $error("floor low byte nonzero");

    // zero write reloads default and pulses clear
    sequence zeroWriteSeq;
        loadedReg && cvlReload;
    endsequence
    sequence reloadSeenSeq;
        (cvlReg == cvlDefault) && chargeCurrentClear;
    endsequence
    // A second zero write right behind the first keeps the pulse up one more cycle
    cvl_zero_reload_a: assert property (@(posedge sys_clk) disable iff (rst)
        zeroWriteSeq |=> reloadSeenSeq ##1 (!chargeCurrentClear || $past(cvlReload)))
        else $error("zero write did not reload");

    // limit holds strap default right after load
    cvl_default_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(loadedReg) |-> (cvlReg == cvlDefault))
        else $error("limit default wrong");

    // floor holds strap default right after load
    svf_default_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(loadedReg) |-> (svfReg == svfDefault))
        else $error("floor default wrong");

    // read returns held value one cycle later
    read_back_a: assert property (@(posedge sys_clk) disable iff (rst)
        (hostCmd.rdStb && hostCmd.cmd == CHARGE_VOLTAGE_LIMIT_OFS) |=> rdValid && (rdData == $past(cvlReg)))
        else $error("read data mismatch");

    // floor read returns held value one cycle later
    svf_read_back_a: assert property (@(posedge sys_clk) disable iff (rst)
        (hostCmd.rdStb && hostCmd.cmd == SYSTEM_VOLTAGE_FLOOR_OFS) |=> rdValid && (rdData == $past(svfReg)))
        else $error("floor read data mismatch");

    // a write with a reserved bit set is flagged invalid
    rsvd_invalid_a: assert property (@(posedge sys_clk) disable iff (rst)
        ((hitCvl && cvlRsvdBad) || (hitSvf && svfRsvdBad)) |=> wrInvalid)
        else $error("reserved write not flagged");

endmodule : charge_voltage_limit_regs

// File: verif/smbus_host_model.sv
// Host model: issues single word commands to the setpoint registers
`timescale 1ns/100ps
module smbus_host_model (
    input wire logic sys_clk,
    input wire logic [15:0] rdData,
    input wire logic rdValid,
    input wire logic wrInvalid,
    input wire logic chargeCurrentClear,
    output charge_voltage_limit_pkg::word_cmd_t hostCmd
);
    import charge_voltage_limit_pkg::*;

    initial hostCmd = '0;

    task automatic hostWrite(input logic [7:0] cmd, input logic [15:0] data, output logic inv, output logic clr);
        @(negedge sys_clk);
        hostCmd = '{wrStb: 1'b1, rdStb: 1'b0, cmd: cmd, data: data};
        @(negedge sys_clk);
        inv = wrInvalid;
        clr = chargeCurrentClear;
        // Released lines show the inverse so a stale copy cannot pass
        hostCmd = '{wrStb: 1'b0, rdStb: 1'b0, cmd: ~cmd, data: ~data};
    endtask : hostWrite

    task automatic hostRead(input logic [7:0] cmd, output logic [15:0] d, output logic v);
        @(negedge sys_clk);
        hostCmd = '{wrStb: 1'b0, rdStb: 1'b1, cmd: cmd, data: 16'hffff};
        @(negedge sys_clk);
        d = rdData;
        v = rdValid;
        hostCmd = '{wrStb: 1'b0, rdStb: 1'b0, cmd: ~cmd, data: 16'h0000};
    endtask : hostRead
endmodule : smbus_host_model

// File: verif/tb_top.sv
// Testbench: strap defaults, writes, refusals and zero reload of the setpoint registers
`timescale 1ns/100ps
`define CHECK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin nErrors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    import charge_voltage_limit_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] strap = 2'b00;
    word_cmd_t hostCmd;
    logic [15:0] rdData, limit, floorV;
    logic rdValid, wrInvalid, clear, inv, clr, v;
    logic [15:0] d;
    int nErrors = 0;
    int totalChecks = 0;

    charge_voltage_limit_regs charge_voltage_limit_regs_i (.sys_clk(sys_clk), .rst(rst),
        .cell_count_strap_pin(strap), .hostCmd(hostCmd), .rdData(rdData), .rdValid(rdValid),
        .wrInvalid(wrInvalid), .chargeVoltageLimit(limit), .systemVoltageFloor(floorV),
        .chargeCurrentClear(clear));
    smbus_host_model smbus_host_model_i (.sys_clk(sys_clk), .rdData(rdData), .rdValid(rdValid),
        .wrInvalid(wrInvalid), .chargeCurrentClear(clear), .hostCmd(hostCmd));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    function automatic logic [15:0] limitDefault(input int cells);
        int mv [4] = '{4192, 8400, 12592, 16800};
        return 16'((mv[cells] / 16) << 4);
    endfunction : limitDefault

    function automatic logic [15:0] floorDefault(input int cells);
        int mv [4] = '{3584, 6144, 9216, 12288};
        return 16'((mv[cells] / 256) << 8);
    endfunction : floorDefault

    task automatic test_done;
        $display("errors %0d of %0d checks", nErrors, totalChecks);
        if (nErrors == 0 && totalChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic applyReset(input int cells);
        @(negedge sys_clk);
        rst = 1'b1;
        strap = 2'(cells);
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        // First request is allowed from the fifth edge after release
        repeat (8) @(negedge sys_clk);
    endtask : applyReset

    task automatic strapDefaults;
        for (int c = 0; c < 4; c++) begin
            applyReset(c);
            `CHECK(limit, limitDefault(c))
            `CHECK(floorV, floorDefault(c))
            smbus_host_model_i.hostRead(SYSTEM_VOLTAGE_FLOOR_OFS, d, v);
            `CHECK({v, d}, {1'b1, floorDefault(c)})
        end
    endtask : strapDefaults

    task automatic legalWrites;
        smbus_host_model_i.hostWrite(CHARGE_VOLTAGE_LIMIT_OFS, 16'h20df, inv, clr);
        `CHECK({inv, clr, limit}, {2'b00, 16'h20d0})
        smbus_host_model_i.hostRead(CHARGE_VOLTAGE_LIMIT_OFS, d, v);
        `CHECK({v, d}, {1'b1, 16'h20d0})
        smbus_host_model_i.hostWrite(SYSTEM_VOLTAGE_FLOOR_OFS, 16'h3fff, inv, clr);
        `CHECK({inv, floorV}, {1'b0, 16'h3f00})
        smbus_host_model_i.hostRead(SYSTEM_VOLTAGE_FLOOR_OFS, d, v);
        `CHECK({v, d}, {1'b1, 16'h3f00})
        smbus_host_model_i.hostRead(CHARGE_CURRENT_SETPOINT_OFS, d, v);
        `CHECK({v, d}, {1'b1, 16'h0000})
    endtask : legalWrites

    task automatic refusals;
        logic [7:0] cmds [9] = '{8'h15, 8'h15, 8'h15, 8'h15, 8'h15, 8'h3e, 8'h3e, 8'h3e, 8'h3e};
        logic [15:0] words [9] = '{16'ha0d0, 16'h03f0, 16'h0400, 16'h4b10, 16'h4b00,
            16'h0300, 16'h0400, 16'h4400, 16'h8f00};
        logic bad [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        logic [15:0] expLimit, expFloor;
        expLimit = limit;
        expFloor = floorV;
        for (int i = 0; i < 9; i++) begin
            // range ends and reserved bits; entries with bad clear are legal and must load
            smbus_host_model_i.hostWrite(cmds[i], words[i], inv, clr);
            if (!bad[i] && cmds[i] == 8'h15) expLimit = words[i];
            if (!bad[i] && cmds[i] == 8'h3e) expFloor = words[i];
            `CHECK(inv, bad[i])
            `CHECK({limit, floorV}, {expLimit, expFloor})
        end
    endtask : refusals

    task automatic zeroReload;
        smbus_host_model_i.hostWrite(CHARGE_VOLTAGE_LIMIT_OFS, 16'h1230, inv, clr);
        `CHECK({clr, limit}, {1'b0, 16'h1230})
        smbus_host_model_i.hostWrite(CHARGE_VOLTAGE_LIMIT_OFS, 16'h0005, inv, clr);
        `CHECK({inv, clr, limit}, {2'b01, limitDefault(3)})
        @(negedge sys_clk);
        `CHECK(clear, 1'b0)
    endtask : zeroReload

    initial begin
        strapDefaults();
        legalWrites();
        refusals();
        zeroReload();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        nErrors++;
        test_done();
    end
endmodule : tb_top
